//--- verilog/host_register_port.sv
// Purpose: Host register port of a two channel serial controller.
// Assumes: Bus strobes and pins are asynchronous to core_clk.
// Notes: Data and status of the serial engines arrive on plain ports.
// Functional notes
// R1: Data select high reaches data registers directly.
// R2: Point-high code selects registers eight to fifteen.
// R3: Other codes select registers zero to seven.
// R4: Access after pointer write clears pointer bits.
// R5: Host reaches indirect registers in two accesses.
// R6: Channel select high is A, low B.
// R7: Point-high decode holds data, gaps and aliases.
// R8: FIFO off, registers four to seven image.
// R9: Vector and master control shared by channels.
// R10: Vector unmodified on A, status on B.
// R11: Pending flags read through channel A only.
// R12: FIFO enable exposes frame count registers.
// R13: Alternate enable redirects sync pattern writes.
// R14: Transfer mode picks wait or request function.
// R15: Request asserts when data byte is ready.
// R16: Wait asserts while transfer not ready.
// R17: Terminal ready can act as transmit request.
// R18: Strobes are synchronised before any use.
// R19: Host spaces accesses by three and half clocks.
// R20: Host holds selects stable; enable gates strobes.
// R21: Host programs mode first, enables last.
`timescale 1ns/10ps
`default_nettype none
module host_register_port (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic chip_enable_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic data_cmd_sel,
    input wire logic chan_sel_a,
    input wire logic interrupt_acknowledge_n,
    input wire logic [7:0] data_in,
    input wire logic [1:0][7:0] rx_data,
    input wire logic [1:0][7:0] main_status,
    input wire logic [1:0][7:0] special_status,
    input wire logic [1:0][7:0] misc_status,
    input wire logic [1:0][7:0] count_low,
    input wire logic [1:0][7:0] count_high,
    input wire logic [5:0] pending_flag,
    input wire logic [2:0] vector_status,
    input wire logic [1:0] rx_ready,
    input wire logic [1:0] tx_ready,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic [7:0] tx_data,
    output logic [1:0] tx_strobe,
    output logic [1:0] rx_read,
    output logic [1:0] wait_request_n,
    output logic [1:0] terminal_ready_n,
    output logic [7:0] vector_reg,
    output logic [7:0] master_int_ctrl,
    output logic [1:0][7:0] alt_frame_opts
);
    import host_port_pkg::*;

    logic [PIN_WIDTH-1:0] meta_ff;
    logic [PIN_WIDTH-1:0] sync_ff;
    logic rd_act_q_ff;
    logic wr_act_q_ff;
    logic [7:0] wr_data_ff;
    logic [1:0][7:0] ptr_ff;
    logic [1:0][15:0][7:0] wreg_ff;
    logic [7:0] vector_ff;
    logic [7:0] master_ff;
    logic [1:0][7:0] alt_ff;
    logic [7:0] data_out_ff;
    logic data_oe_ff;
    logic [7:0] tx_data_ff;
    logic [1:0] tx_strobe_ff;
    logic [1:0] rx_read_ff;
    logic [1:0] wait_request_n_ff;
    logic [1:0] terminal_ready_n_ff;

    // Pins pass two flops; the first stage feeds only the second. [R18]
    // Both stages reset to the idle pin levels, so no false strobe edge follows reset.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_ff <= PIN_IDLE;
            sync_ff <= PIN_IDLE;
        end else begin
            meta_ff <= {interrupt_acknowledge_n, chan_sel_a, data_cmd_sel, chip_enable_n, read_n, write_n, data_in};
            sync_ff <= meta_ff;
        end
    end

    // Decoded view of the synchronised pins.
    wire [7:0] s_data = sync_ff[7:0];
    wire s_wr_n = sync_ff[8];
    wire s_rd_n = sync_ff[9];
    wire s_ce_n = sync_ff[10];
    wire s_dc = sync_ff[11];
    wire s_ab = sync_ff[12];
    wire s_ack_n = sync_ff[13];
    // An acknowledge cycle is no register access, so it is kept out here.
    wire rd_act = ~s_ce_n & ~s_rd_n & s_ack_n; // [R20]
    wire wr_act = ~s_ce_n & ~s_wr_n;
    wire rd_start = rd_act & ~rd_act_q_ff;
    wire rd_end = ~rd_act & rd_act_q_ff;
    wire wr_end = ~wr_act & wr_act_q_ff;
    wire ch = ~s_ab; // [R6]
    wire [7:0] ptr = ptr_ff[ch];
    wire point_high = ptr[PTR_HIGH_BIT] & ~ptr[PTR_CODE5_BIT] & ~ptr[PTR_CODE6_BIT]; // [R2]
    wire [3:0] idx = {point_high, ptr[2:0]}; // [R2] [R3]
    wire is_data = s_dc | (idx == 4'h8); // [R1] [R7]
    wire fifo_on = wreg_ff[ch][IDX_ENHANCE][ENH_FIFO_BIT];
    wire alt_on = wreg_ff[ch][IDX_ENHANCE][ENH_ALT_BIT];
    wire cmd_end = (rd_end | wr_end) & ~s_dc;
    wire ptr_load = wr_end & ~s_dc & (idx == IDX_POINTER);

    // Vector with status bits inserted, used on channel B reads.
    wire [7:0] vector_mod = {vector_ff[7:4], vector_status, vector_ff[0]}; // [R10]
    wire [7:0] vector_rd = (ch == 1'(CH_A)) ? vector_ff : vector_mod; // [R10]
    wire [7:0] pending_rd = (ch == 1'(CH_A)) ? {2'h0, pending_flag} : REG_RESET; // [R11]
    wire [1:0] low_sel = idx[1:0];
    // Low registers 4 and 5 alias 0 and 1; 6 and 7 alias 2 and 3 unless the frame FIFO is on.
    wire low_image = ~idx[2] | ~fifo_on | ~idx[1]; // [R8] [R12]
    wire [7:0] low_base = (low_sel == 2'd0) ? main_status[ch] :
                          (low_sel == 2'd1) ? special_status[ch] :
                          (low_sel == 2'd2) ? vector_rd : pending_rd;
    wire [7:0] low_rd = low_image ? low_base : (idx[0] ? count_high[ch] : count_low[ch]); // [R8] [R12]
    // High decode: 1 reads zero, 3 and 7 mirror 15, 2 and 6 mirror 10.
    wire [7:0] high_rd = (idx[1:0] == 2'd1 && !idx[2]) ? REG_RESET : // [R7]
                         (idx[1:0] == 2'd0) ? wreg_ff[ch][IDX_TIME_LOW] :
                         (idx[1:0] == 2'd1) ? wreg_ff[ch][IDX_TIME_HIGH] :
                         (idx[1:0] == 2'd2) ? misc_status[ch] : wreg_ff[ch][IDX_ENHANCE];
    wire [7:0] read_mux = is_data ? rx_data[ch] : (point_high ? high_rd : low_rd); // [R1] [R7]

    // Wait/request per channel from the transfer mode register.
    wire [1:0] nxt_wait_request_n;
    wire [1:0] nxt_terminal_ready_n;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            wire [7:0] xm = wreg_ff[gi][IDX_TRANSFER_MODE];
            wire ready = xm[XFER_RX_BIT] ? rx_ready[gi] : tx_ready[gi];
            // Request mode drives on readiness, wait mode on the lack of it.
            assign nxt_wait_request_n[gi] = ~(xm[XFER_ENABLE_BIT] & (xm[XFER_REQUEST_BIT] ? ready : ~ready)); // [R14] [R15] [R16]
            assign nxt_terminal_ready_n[gi] = wreg_ff[gi][IDX_DTR_FUNC][DTR_REQUEST_BIT] ? ~tx_ready[gi] : 1'b1; // [R17]
        end
    endgenerate

    // Edge history of the synchronised strobes.
    // Write data is held from inside the strobe, since a host may change it as soon as the strobe rises.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rd_act_q_ff <= 1'b0;
            wr_act_q_ff <= 1'b0;
            wr_data_ff <= REG_RESET;
            wait_request_n_ff <= 2'b11;
            terminal_ready_n_ff <= 2'b11;
        end else begin
            rd_act_q_ff <= rd_act;
            wr_act_q_ff <= wr_act;
            if (wr_act) begin
                wr_data_ff <= s_data;
            end
            wait_request_n_ff <= nxt_wait_request_n;
            terminal_ready_n_ff <= nxt_terminal_ready_n;
        end
    end

    // Read path: data is latched at the start so it holds for the cycle.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            data_out_ff <= REG_RESET;
            data_oe_ff <= 1'b0;
            rx_read_ff <= 2'b00;
        end else begin
            rx_read_ff <= 2'b00;
            if (rd_start) begin
                data_out_ff <= read_mux;
                data_oe_ff <= 1'b1;
                rx_read_ff[ch] <= is_data; // [R1]
            end else if (rd_end) begin
                data_oe_ff <= 1'b0;
            end
        end
    end

    // Write path acts at the strobe end, using the data held from inside the strobe.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ptr_ff <= '0;
            wreg_ff <= '0;
            vector_ff <= REG_RESET;
            master_ff <= REG_RESET;
            alt_ff <= '0;
            tx_data_ff <= REG_RESET;
            tx_strobe_ff <= 2'b00;
        end else begin
            tx_strobe_ff <= 2'b00;
            if (ptr_load) begin
                ptr_ff[ch] <= wr_data_ff;
            end else if (cmd_end) begin
                ptr_ff[ch] <= ptr & PTR_CLEAR_MASK; // [R4]
            end
            if (wr_end) begin
                if (is_data) begin
                    tx_data_ff <= wr_data_ff; // [R1]
                    tx_strobe_ff[ch] <= 1'b1;
                end else if (idx == IDX_VECTOR) begin
                    vector_ff <= wr_data_ff; // [R9]
                end else if (idx == IDX_MASTER_INT) begin
                    master_ff <= wr_data_ff; // [R9]
                end else if (idx == IDX_SYNC_PATTERN && alt_on) begin
                    alt_ff[ch] <= wr_data_ff; // [R13]
                end else if (idx != IDX_POINTER) begin
                    wreg_ff[ch][idx] <= wr_data_ff;
                end
            end
        end
    end

    assign data_out = data_out_ff;
    assign data_oe = data_oe_ff;
    assign tx_data = tx_data_ff;
    assign tx_strobe = tx_strobe_ff;
    assign rx_read = rx_read_ff;
    assign wait_request_n = wait_request_n_ff;
    assign terminal_ready_n = terminal_ready_n_ff;
    assign vector_reg = vector_ff;
    assign master_int_ctrl = master_ff;
    assign alt_frame_opts = alt_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_rd_cmd_img;
        rd_start && !is_data && !point_high && idx[2] && !fifo_on;
    endsequence

    a_data_read_pulse: assert property (rd_start && s_dc |=> rx_read_ff[$past(ch)] ##1 !rx_read_ff[$past(ch, 2)]) // [R1]
        else $error("data read gave no single read pulse");
    a_ptr_clears: assert property (cmd_end && !ptr_load |=> ptr_ff[$past(ch)][4:0] == 5'h00) // [R4]
        else $error("pointer low bits not cleared");
    a_chan_steer: assert property (wr_end && s_dc && s_ab |=> tx_strobe_ff == 2'b01) // [R6]
        else $error("channel A write strobed wrong channel");
    a_vector_shared: assert property (wr_end && !is_data && idx == IDX_VECTOR |=> vector_ff == $past(wr_data_ff)) // [R9]
        else $error("vector write lost");
    a_image_read: assert property (s_rd_cmd_img |=> data_out_ff == $past(low_base) && data_oe_ff) // [R8]
        else $error("image read wrong");
    a_alt_redirect: assert property (wr_end && !is_data && idx == IDX_SYNC_PATTERN && alt_on
        |=> alt_ff[$past(ch)] == $past(wr_data_ff)) // [R13]
        else $error("alternate write not redirected");
    a_pending_b: assert property (rd_start && !is_data && !point_high && idx == IDX_PENDING && ch
        |=> data_out_ff == REG_RESET) // [R11]
        else $error("pending flags visible on channel B");
    a_request_mode: assert property (wreg_ff[0][IDX_TRANSFER_MODE][XFER_ENABLE_BIT]
        && wreg_ff[0][IDX_TRANSFER_MODE][XFER_REQUEST_BIT] && !wreg_ff[0][IDX_TRANSFER_MODE][XFER_RX_BIT]
        && tx_ready[0] |=> !wait_request_n_ff[0]) // [R15]
        else $error("request not asserted when ready");
    a_wait_mode: assert property (wreg_ff[1][IDX_TRANSFER_MODE][XFER_ENABLE_BIT]
        && !wreg_ff[1][IDX_TRANSFER_MODE][XFER_REQUEST_BIT] && wreg_ff[1][IDX_TRANSFER_MODE][XFER_RX_BIT]
        && !rx_ready[1] |=> !wait_request_n_ff[1]) // [R16]
        else $error("wait not asserted when not ready");
endmodule : host_register_port
`default_nettype wire

//--- verilog/host_port_pkg.sv
// Purpose: Shared constants for the host register port.
// Assumes: 20 MHz core clock, channel A is index 0 and channel B is index 1.
// Notes: Register indices follow the pointer decode of the port.
package host_port_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int RECOVERY_TENTHS_CLK = 35;
    localparam int RECOVERY_CYCLES = (RECOVERY_TENTHS_CLK + 9) / 10;
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    localparam int PTR_HIGH_BIT = 3;
    localparam int PTR_CODE5_BIT = 5;
    localparam int PTR_CODE6_BIT = 6;
    localparam logic [7:0] PTR_CLEAR_MASK = 8'hE0;
    localparam logic [3:0] IDX_POINTER = 4'h0;
    localparam logic [3:0] IDX_TRANSFER_MODE = 4'h1;
    localparam logic [3:0] IDX_VECTOR = 4'h2;
    localparam logic [3:0] IDX_PENDING = 4'h3;
    localparam logic [3:0] IDX_SYNC_PATTERN = 4'h7;
    localparam logic [3:0] IDX_MASTER_INT = 4'h9;
    localparam logic [3:0] IDX_MISC_STATUS = 4'hA;
    localparam logic [3:0] IDX_TIME_LOW = 4'hC;
    localparam logic [3:0] IDX_TIME_HIGH = 4'hD;
    localparam logic [3:0] IDX_DTR_FUNC = 4'hE;
    localparam logic [3:0] IDX_ENHANCE = 4'hF;
    localparam logic [3:0] IDX_COUNT_LOW = 4'h6;
    localparam logic [3:0] IDX_COUNT_HIGH = 4'h7;
    localparam int ENH_ALT_BIT = 0;
    localparam int ENH_FIFO_BIT = 2;
    localparam int XFER_ENABLE_BIT = 7;
    localparam int XFER_REQUEST_BIT = 6;
    localparam int XFER_RX_BIT = 5;
    localparam int DTR_REQUEST_BIT = 2;
    localparam int VEC_STATUS_LO = 1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int PIN_WIDTH = 14;
    localparam logic [PIN_WIDTH-1:0] PIN_IDLE = 14'h2700; // Strobes, enable and acknowledge rest high.
endpackage : host_port_pkg

//--- sim/host_bus_model.sv
// Purpose: Behavioural host bus master facing the register port.
// Assumes: Pins change just after a rising edge of core_clk.
// Notes: Each access holds its strobe four cycles and then rests five, so outputs have settled on return.
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
    input wire logic core_clk,
    input wire logic [7:0] data_out,
    output logic chip_enable_n,
    output logic read_n,
    output logic write_n,
    output logic data_cmd_sel,
    output logic chan_sel_a,
    output logic interrupt_acknowledge_n,
    output logic [7:0] data_in
);
    // Idle bus at time zero; acknowledge cycles are not exercised.
    initial begin
        chip_enable_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
        data_cmd_sel = 1'b0;
        chan_sel_a = 1'b1;
        interrupt_acknowledge_n = 1'b1;
        data_in = 8'h00;
    end
    // Selects stay put while the strobe is low; falling edges sit ten clocks apart.
    task automatic bus(input logic wr, input logic dc, input logic cha, input logic [7:0] din,
                       output logic [7:0] dout);
        @(posedge core_clk);
        chip_enable_n <= 1'b0;
        read_n <= wr;
        write_n <= !wr;
        data_cmd_sel <= dc;
        chan_sel_a <= cha;
        data_in <= din;
        repeat (4) @(posedge core_clk);
        dout = data_out;
        chip_enable_n <= 1'b1;
        read_n <= 1'b1;
        write_n <= 1'b1;
        data_in <= ~din; // Released data must not keep showing the last byte.
        repeat (5) @(posedge core_clk);
    endtask : bus
    // Indirect registers need a pointer write first; index zero is reached at once.
    task automatic reg_rw(input logic wr, input logic cha, input logic [3:0] idx, input logic [7:0] din,
                          output logic [7:0] dout);
        if (idx != 4'h0) begin
            bus(1'b1, 1'b0, cha, {4'h0, idx}, dout);
        end
        bus(wr, 1'b0, cha, din, dout);
    endtask : reg_rw
endmodule : host_bus_model
`default_nettype wire

//--- sim/host_register_port_tb.sv
// Purpose: Self-checking bench for the host register port.
// Assumes: Status inputs are held at distinct values per channel.
// Notes: Expected bytes come from the status values set here.
`timescale 1ns/10ps
`default_nettype none
module host_register_port_tb;
    import host_port_pkg::*;
    logic core_clk, reset, ce_n, rd_n, wr_n, dc, cha, ack_n, data_oe;
    logic [7:0] din, data_out, tx_data, vector_reg, master_int_ctrl, seen;
    logic [1:0][7:0] rx_data, main_status, special_status, misc_status, count_low, count_high, alt_frame_opts;
    logic [5:0] pending_flag;
    logic [2:0] vector_status;
    logic [1:0] rx_ready, tx_ready, tx_strobe, rx_read, wait_request_n, terminal_ready_n;
    int error_cnt, num_checks, cycle_cnt;
    logic oe_q = 1'b0;
    logic [7:0] oe_rise_cnt = 8'h00, rx_b_cnt = 8'h00, tx_a_cnt = 8'h00;
    host_register_port host_register_port_inst (.core_clk(core_clk), .reset(reset), .chip_enable_n(ce_n),
        .read_n(rd_n), .write_n(wr_n), .data_cmd_sel(dc), .chan_sel_a(cha), .interrupt_acknowledge_n(ack_n),
        .data_in(din), .rx_data(rx_data), .main_status(main_status), .special_status(special_status),
        .misc_status(misc_status), .count_low(count_low), .count_high(count_high), .pending_flag(pending_flag),
        .vector_status(vector_status), .rx_ready(rx_ready), .tx_ready(tx_ready), .data_out(data_out),
        .data_oe(data_oe), .tx_data(tx_data), .tx_strobe(tx_strobe), .rx_read(rx_read),
        .wait_request_n(wait_request_n), .terminal_ready_n(terminal_ready_n), .vector_reg(vector_reg),
        .master_int_ctrl(master_int_ctrl), .alt_frame_opts(alt_frame_opts));
    host_bus_model host_bus_model_inst (.core_clk(core_clk), .data_out(data_out), .chip_enable_n(ce_n),
        .read_n(rd_n), .write_n(wr_n), .data_cmd_sel(dc), .chan_sel_a(cha), .interrupt_acknowledge_n(ack_n),
        .data_in(din));
    // Clock at 50 ns period.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Prints the verdict and stops the run.
    task automatic complete_run;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // One comparison; a mismatch is reported at once.
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Hang guard: the whole sequence needs well under a thousand cycles.
    always @(posedge core_clk) begin
        cycle_cnt++;
        if (cycle_cnt == 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    // Counts read windows and one-cycle pulses for the closing checks.
    always @(posedge core_clk) begin
        oe_q <= data_oe;
        if (data_oe && !oe_q) begin
            oe_rise_cnt <= oe_rise_cnt + 8'h01;
        end
        if (rx_read[1]) begin
            rx_b_cnt <= rx_b_cnt + 8'h01;
        end
        if (tx_strobe[0]) begin
            tx_a_cnt <= tx_a_cnt + 8'h01;
        end
    end
    // Main sequence; every access goes through the bus model.
    initial begin
        reset = 1'b1;
        rx_data = {8'h3c, 8'hc3};
        main_status = {8'h21, 8'h12};
        special_status = {8'h44, 8'h41};
        misc_status = {8'h66, 8'h61};
        count_low = {8'h77, 8'h71};
        count_high = {8'h88, 8'h81};
        pending_flag = 6'h2d;
        vector_status = 3'h2;
        rx_ready = 2'b00;
        tx_ready = 2'b00;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        check("wait_request_n", {6'h00, wait_request_n}, 8'h03);
        check("terminal_ready_n", {6'h00, terminal_ready_n}, 8'h03);
        check("vector_reg", vector_reg, REG_RESET);
        host_bus_model_inst.bus(1'b1, 1'b1, 1'b1, 8'h96, seen);
        check("tx_data", tx_data, 8'h96);
        host_bus_model_inst.bus(1'b0, 1'b1, 1'b0, 8'h00, seen);
        check("data read B", seen, 8'h3c);
        host_bus_model_inst.reg_rw(1'b1, 1'b0, 4'h2, 8'h5a, seen);
        check("vector_reg", vector_reg, 8'h5a);
        host_bus_model_inst.reg_rw(1'b0, 1'b1, 4'h2, 8'h00, seen);
        check("vector via A", seen, 8'h5a);
        host_bus_model_inst.reg_rw(1'b0, 1'b0, 4'h2, 8'h00, seen);
        check("vector via B", seen, {4'h5, 3'h2, 1'b0});
        host_bus_model_inst.reg_rw(1'b1, 1'b1, 4'h9, 8'h3c, seen);
        check("master_int_ctrl", master_int_ctrl, 8'h3c);
        host_bus_model_inst.reg_rw(1'b1, 1'b0, 4'hf, 8'h05, seen);
        host_bus_model_inst.reg_rw(1'b0, 1'b0, 4'hb, 8'h00, seen);
        check("code 3 high", seen, 8'h05);
        host_bus_model_inst.reg_rw(1'b0, 1'b0, 4'he, 8'h00, seen);
        check("code 6 high", seen, 8'h66);
        host_bus_model_inst.reg_rw(1'b0, 1'b0, 4'h8, 8'h00, seen);
        check("code 0 high", seen, 8'h3c);
        host_bus_model_inst.bus(1'b0, 1'b0, 1'b0, 8'h00, seen);
        check("pointer cleared", seen, 8'h21);
        // Bit 3 set with bits 5 and 6 set is not the point-high code.
        host_bus_model_inst.bus(1'b1, 1'b0, 1'b1, 8'h6b, seen);
        host_bus_model_inst.bus(1'b0, 1'b0, 1'b1, 8'h00, seen);
        check("pending via A", seen, {2'b00, 6'h2d});
        host_bus_model_inst.reg_rw(1'b0, 1'b0, 4'h3, 8'h00, seen);
        check("pending via B", seen, 8'h00);
        host_bus_model_inst.reg_rw(1'b0, 1'b0, 4'h6, 8'h00, seen);
        check("count low", seen, 8'h77);
        host_bus_model_inst.reg_rw(1'b0, 1'b0, 4'h7, 8'h00, seen);
        check("count high", seen, 8'h88);
        host_bus_model_inst.reg_rw(1'b0, 1'b1, 4'h4, 8'h00, seen);
        check("image 0", seen, 8'h12);
        host_bus_model_inst.reg_rw(1'b0, 1'b1, 4'h7, 8'h00, seen);
        check("image 3", seen, {2'b00, 6'h2d});
        host_bus_model_inst.reg_rw(1'b1, 1'b0, 4'h7, 8'ha5, seen);
        check("alt opts B", alt_frame_opts[1], 8'ha5);
        // Interrupt registers were set above; the transfer enable comes last.
        host_bus_model_inst.reg_rw(1'b1, 1'b1, 4'h1, 8'h80, seen);
        check("wait not ready", {7'h00, wait_request_n[0]}, 8'h00);
        tx_ready <= 2'b01;
        repeat (5) @(posedge core_clk);
        check("wait ready", {7'h00, wait_request_n[0]}, 8'h01);
        host_bus_model_inst.reg_rw(1'b1, 1'b0, 4'h1, 8'ha0, seen);
        check("wait B not ready", {7'h00, wait_request_n[1]}, 8'h00);
        host_bus_model_inst.reg_rw(1'b1, 1'b1, 4'h1, 8'hc0, seen);
        check("request ready", {7'h00, wait_request_n[0]}, 8'h00);
        host_bus_model_inst.reg_rw(1'b1, 1'b1, 4'he, 8'h04, seen);
        check("tx request", {7'h00, terminal_ready_n[0]}, 8'h00);
        check("data_oe idle", {7'h00, data_oe}, 8'h00);
        check("data_oe rises", oe_rise_cnt, 8'h0d);
        check("rx_read B", rx_b_cnt, 8'h02);
        check("tx_strobe A", tx_a_cnt, 8'h01);
        complete_run();
    end
endmodule : host_register_port_tb
`default_nettype wire
